//--- src/swt_defines.vh
// register offsets, field positions, reset values, top values and response codes of the waveform timer
`ifndef SWT_DEFINES_VH
`define SWT_DEFINES_VH
`define SWT_OFF_CTRL_A 8'h00
`define SWT_OFF_CTRL_B 8'h04
`define SWT_OFF_CMP_A 8'h08
`define SWT_OFF_CMP_B 8'h0c
`define SWT_OFF_CAPTURE 8'h10
`define SWT_OFF_COUNTER 8'h14
`define SWT_OFF_STATUS 8'h18
`define SWT_OFF_MASK 8'h1c
`define SWT_OFF_DIR 8'h20
`define SWT_CTRL_A_RST 8'h00
`define SWT_CTRL_A_WMASK 8'hf3
`define SWT_CTRL_B_WMASK 8'h18
`define SWT_WGM_HI_LSB 3
`define SWT_OM_A_LSB 6
`define SWT_OM_B_LSB 4
`define SWT_ST_OVF 0
`define SWT_ST_MATCH_A 1
`define SWT_ST_MATCH_B 2
`define SWT_TOP_MAX 16'hffff
`define SWT_TOP_8 16'h00ff
`define SWT_TOP_9 16'h01ff
`define SWT_TOP_10 16'h03ff
`define SWT_BOTTOM 16'h0000
`define SWT_RESP_OKAY 2'b00
`define SWT_RESP_SLVERR 2'b10
`endif

//--- src/swt_timer.v
// 16-bit waveform timer: counter, compare units, output control and axi4-lite registers
//
// What this block does
// - everything runs on mclk and the tick input only enables one counter step per cycle.
// - in phase and frequency correct modes buffered compare values load at bottom, not top.
// - a nonzero output-mode field hands that channel's pin over to its compare output, per channel, except 01 where that channel cannot toggle.
// - the compare output drives the pin only when the pin's direction bit selects output.
// - in normal and clear-on-match modes 00 disconnects, 01 toggles, 10 clears, 11 sets on match.
// - in fast pwm 10 clears on match and sets at top, 11 sets on match and clears at top.
// - in fast pwm with mode 01 only mode 15 toggles output a, b stays disconnected, else both off.
// - in fast pwm a match at compare equal to top with the high mode bit set is replaced by top action.
// - in dual-slope modes 10 clears on up match and sets on down match, 11 does the opposite.
// - in dual-slope modes with 01 only mode 9 toggles output a, otherwise both disconnected.
// - the 4-bit mode is control a bits 1:0 plus two high bits held in control b.
// - mode 0 tops at 0xffff, modes 4 and 12 top from compare a or capture, immediate update, overflow at max.
// - phase correct modes 1-3 top at 0x00ff/0x01ff/0x03ff, 10 and 11 from capture or compare a, update top.
// - fast pwm modes 5-7 use 8/9/10-bit tops, 14 and 15 capture or compare a, update and overflow at top.
// - modes 8 and 9 top from capture or compare a, update and overflow at bottom.
// - dual-slope counting goes bottom to top and back, stepping down on the tick after top is reached, with no extra hold at top.
`timescale 1ns/1ps
`include "swt_defines.vh"
module swt_timer #(
  parameter CNT_W = 16
) (
  input wire mclk, // system clock
  input wire reset, // synchronous active-high reset
  input wire timer_tick_enable, // one-cycle count enable from prescaler logic
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read valid
  input wire s_axi_rready, // read ready
  input wire port_out_a, // ordinary port data for pin a
  input wire port_out_b, // ordinary port data for pin b
  output wire pin_out_a, // pin a output level
  output wire pin_oe_n_a, // pin a driver enable, low drives
  output wire pin_out_b, // pin b output level
  output wire pin_oe_n_b, // pin b driver enable, low drives
  output wire compare_out_a, // raw compare output a
  output wire compare_out_b, // raw compare output b
  output wire irq // level interrupt
);
  localparam [3:0] M_NORMAL = 4'd0;
  localparam [3:0] M_CTC_A = 4'd4;
  localparam [3:0] M_PFC_CAP = 4'd8;
  localparam [3:0] M_PFC_A = 4'd9;
  localparam [3:0] M_PC_CAP = 4'd10;
  localparam [3:0] M_PC_A = 4'd11;
  localparam [3:0] M_CTC_CAP = 4'd12;
  localparam [3:0] M_FAST_CAP = 4'd14;
  localparam [3:0] M_FAST_A = 4'd15;

  reg [7:0] timer_wave_control_a_q;
  reg [1:0] wave_gen_mode_high_q;
  reg [CNT_W-1:0] compare_value_a_q;
  reg [CNT_W-1:0] compare_value_b_q;
  reg [CNT_W-1:0] buf_a_q;
  reg [CNT_W-1:0] buf_b_q;
  reg [CNT_W-1:0] capture_value_reg_q;
  reg [CNT_W-1:0] counter_value_q;
  reg down_q;
  reg oc_a_q;
  reg oc_b_q;
  reg [2:0] status_q;
  reg [2:0] mask_q;
  reg [1:0] dir_q;
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire [3:0] wave_gen_mode = {wave_gen_mode_high_q, timer_wave_control_a_q[1:0]};
  wire [1:0] out_mode_a = timer_wave_control_a_q[`SWT_OM_A_LSB+1:`SWT_OM_A_LSB];
  wire [1:0] out_mode_b = timer_wave_control_a_q[`SWT_OM_B_LSB+1:`SWT_OM_B_LSB];

  // class of a mode: 0 non-pwm, 1 fast, 2 phase correct, 3 phase and frequency correct
  function [1:0] mode_class;
    input [3:0] m;
    begin
      case (m)
        4'd5, 4'd6, 4'd7, M_FAST_CAP, M_FAST_A: mode_class = 2'd1;
        4'd1, 4'd2, 4'd3, M_PC_CAP, M_PC_A: mode_class = 2'd2;
        M_PFC_CAP, M_PFC_A: mode_class = 2'd3;
        default: mode_class = 2'd0;
      endcase
    end
  endfunction

  wire [1:0] mclass = mode_class(wave_gen_mode);
  wire dual = mclass[1];
  // fixed tops for the 8/9/10-bit modes, compare a or capture for the register-top modes, else 0xffff
  reg [CNT_W-1:0] top;
  always @* begin
    case (wave_gen_mode)
      4'd1, 4'd5: top = `SWT_TOP_8;
      4'd2, 4'd6: top = `SWT_TOP_9;
      4'd3, 4'd7: top = `SWT_TOP_10;
      M_CTC_A, M_PFC_A, M_PC_A, M_FAST_A: top = compare_value_a_q;
      M_PFC_CAP, M_PC_CAP, M_CTC_CAP, M_FAST_CAP: top = capture_value_reg_q;
      default: top = `SWT_TOP_MAX;
    endcase
  end


  wire at_top = counter_value_q == top;
  wire at_bottom = counter_value_q == `SWT_BOTTOM;
  wire at_max = counter_value_q == `SWT_TOP_MAX;
  wire match_a = counter_value_q == compare_value_a_q;
  wire match_b = counter_value_q == compare_value_b_q;
  // bottom is reached while counting down; skip the first pass after reset
  wire dual_bottom = at_bottom && down_q;

  reg ovf_point;
  always @* begin
    case (mclass)
      2'd0: ovf_point = at_max;
      2'd1: ovf_point = at_top;
      default: ovf_point = dual_bottom;
    endcase
  end
  wire ovf_event = timer_tick_enable && ovf_point;

  reg upd_point;
  always @* begin
    case (mclass)
      2'd3: upd_point = dual_bottom;
      default: upd_point = at_top;
    endcase
  end
  wire upd_event = timer_tick_enable && upd_point;
  wire immediate = mclass == 2'd0;

  // counter
  always @(posedge mclk) begin
    if (reset) begin
      counter_value_q <= `SWT_BOTTOM;
      down_q <= 1'b0;
    end else if (timer_tick_enable) begin
      if (!dual) begin
        down_q <= 1'b0;
        counter_value_q <= (at_top || (wave_gen_mode == M_NORMAL && at_max)) ? `SWT_BOTTOM :
                           counter_value_q + 1'b1;
      end else if (!down_q) begin
        // top lowered below the count: turn now rather than run on to max
        if (at_top || counter_value_q > top) begin
          down_q <= 1'b1;
          counter_value_q <= counter_value_q - 1'b1;
        end else begin
          counter_value_q <= counter_value_q + 1'b1;
        end
      end else if (at_bottom) begin
        down_q <= 1'b0;
        counter_value_q <= counter_value_q + 1'b1;
      end else begin
        counter_value_q <= counter_value_q - 1'b1;
      end
    end
  end

  // compare output of one channel; returns {change, new level}
  function [1:0] wave_next;
    input [1:0] om;
    input [1:0] cls;
    input tog_ok;
    input cur;
    input match;
    input top_hit;
    input cmp_is_top;
    input dn;
    begin
      wave_next = {1'b0, cur};
      case (cls)
        2'd0: begin
          if (match && om != 2'b00) begin
            wave_next = {1'b1, (om == 2'b01) ? ~cur : om[0]};
          end
        end
        2'd1: begin
          if (om[1] && top_hit) begin
            wave_next = {1'b1, ~om[0]};
          end else if (om[1] && match && !cmp_is_top) begin
            wave_next = {1'b1, om[0]};
          end else if (om == 2'b01 && tog_ok && match) begin
            wave_next = {1'b1, ~cur};
          end
        end
        default: begin
          if (om[1] && match) begin
            wave_next = {1'b1, om[0] ^ dn};
          end else if (om == 2'b01 && tog_ok && match) begin
            wave_next = {1'b1, ~cur};
          end
        end
      endcase
    end
  endfunction

  wire tog_ok_a = (mclass == 2'd0) || (mclass == 2'd1 && wave_gen_mode == M_FAST_A) ||
                  (dual && (wave_gen_mode == M_PFC_A || wave_gen_mode == M_FAST_CAP));
  wire [1:0] nxt_a = wave_next(out_mode_a, mclass, tog_ok_a, oc_a_q, match_a, at_top,
                               compare_value_a_q == top, down_q);
  wire [1:0] nxt_b = wave_next(out_mode_b, mclass, mclass == 2'd0, oc_b_q, match_b, at_top,
                               compare_value_b_q == top, down_q);

  always @(posedge mclk) begin
    if (reset) begin
      oc_a_q <= 1'b0;
      oc_b_q <= 1'b0;
    end else if (timer_tick_enable) begin
      if (nxt_a[1]) begin
        oc_a_q <= nxt_a[0];
      end
      if (nxt_b[1]) begin
        oc_b_q <= nxt_b[0];
      end
    end
  end

  // toggle in dual slope only on mode 9/14; mode 14 is fast, so in practice mode 9 toggles
  wire conn_a = (out_mode_a != 2'b00) && (out_mode_a[1] || tog_ok_a);
  wire conn_b = (out_mode_b != 2'b00) && (out_mode_b[1] || mclass == 2'd0);
  assign compare_out_a = oc_a_q;
  assign compare_out_b = oc_b_q;
  assign pin_out_a = conn_a ? oc_a_q : port_out_a;
  assign pin_out_b = conn_b ? oc_b_q : port_out_b;
  assign pin_oe_n_a = ~dir_q[0];
  assign pin_oe_n_b = ~dir_q[1];

  // axi4-lite slave
  // one write in flight: a held pair waits until the response is taken
  wire wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_arready = !s_axi_rvalid;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wval = w_data_q & wmask;

  function [CNT_W-1:0] merge16;
    input [CNT_W-1:0] old;
    input [31:0] nv;
    input [31:0] m;
    begin
      merge16 = (old & ~m[CNT_W-1:0]) | nv[CNT_W-1:0];
    end
  endfunction

  wire wr_ok = aw_addr_q[1:0] == 2'b00 && aw_addr_q <= `SWT_OFF_DIR;
  wire wr_cmp_a = wr_fire && aw_addr_q == `SWT_OFF_CMP_A;
  wire wr_cmp_b = wr_fire && aw_addr_q == `SWT_OFF_CMP_B;
  wire wr_cnt = wr_fire && aw_addr_q == `SWT_OFF_COUNTER;
  // a write to the counter offset blocks the same-cycle match flags; the counter itself is not written
  wire match_evt_a = match_a & timer_tick_enable & ~wr_cnt;
  wire match_evt_b = match_b & timer_tick_enable & ~wr_cnt;
  wire [2:0] evt = {match_evt_b, match_evt_a, ovf_event};
  wire [2:0] w1c_bits = (wr_fire && aw_addr_q == `SWT_OFF_STATUS) ? wval[2:0] : 3'b000;

  always @(posedge mclk) begin
    if (reset) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SWT_RESP_OKAY;
      timer_wave_control_a_q <= `SWT_CTRL_A_RST;
      wave_gen_mode_high_q <= 2'b00;
      buf_a_q <= {CNT_W{1'b0}};
      buf_b_q <= {CNT_W{1'b0}};
      compare_value_a_q <= {CNT_W{1'b0}};
      compare_value_b_q <= {CNT_W{1'b0}};
      capture_value_reg_q <= {CNT_W{1'b0}};
      status_q <= 3'b000;
      mask_q <= 3'b000;
      dir_q <= 2'b00;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `SWT_RESP_OKAY : `SWT_RESP_SLVERR;
        if (w_strb_q[0]) begin
          case (aw_addr_q)
            `SWT_OFF_CTRL_A: timer_wave_control_a_q <= w_data_q[7:0] & `SWT_CTRL_A_WMASK;
            `SWT_OFF_CTRL_B: wave_gen_mode_high_q <= w_data_q[`SWT_WGM_HI_LSB+1:`SWT_WGM_HI_LSB];
            `SWT_OFF_MASK: mask_q <= w_data_q[2:0];
            `SWT_OFF_DIR: dir_q <= w_data_q[1:0];
            default: ;
          endcase
        end
      end
      if (aw_addr_q == `SWT_OFF_CAPTURE && wr_fire) begin
        capture_value_reg_q <= merge16(capture_value_reg_q, wval, wmask);
      end
      if (wr_cmp_a) begin
        buf_a_q <= merge16(buf_a_q, wval, wmask);
      end
      if (wr_cmp_b) begin
        buf_b_q <= merge16(buf_b_q, wval, wmask);
      end
      // immediate modes follow the buffer at once; others wait for the update point
      if (immediate) begin
        compare_value_a_q <= wr_cmp_a ? merge16(buf_a_q, wval, wmask) : buf_a_q;
        compare_value_b_q <= wr_cmp_b ? merge16(buf_b_q, wval, wmask) : buf_b_q;
      end else if (upd_event) begin
        compare_value_a_q <= buf_a_q;
        compare_value_b_q <= buf_b_q;
      end
      // set wins over write-one-to-clear
      status_q <= (status_q & ~w1c_bits) | evt;
    end
  end

  reg [31:0] rd_val;
  always @* begin
    case (s_axi_araddr)
      `SWT_OFF_CTRL_A: rd_val = {24'h000000, timer_wave_control_a_q};
      `SWT_OFF_CTRL_B: rd_val = {27'h0000000, wave_gen_mode_high_q, 3'b000};
      `SWT_OFF_CMP_A: rd_val = {{(32-CNT_W){1'b0}}, buf_a_q};
      `SWT_OFF_CMP_B: rd_val = {{(32-CNT_W){1'b0}}, buf_b_q};
      `SWT_OFF_CAPTURE: rd_val = {{(32-CNT_W){1'b0}}, capture_value_reg_q};
      `SWT_OFF_COUNTER: rd_val = {{(32-CNT_W){1'b0}}, counter_value_q};
      `SWT_OFF_STATUS: rd_val = {29'h00000000, status_q};
      `SWT_OFF_MASK: rd_val = {29'h00000000, mask_q};
      `SWT_OFF_DIR: rd_val = {30'h00000000, dir_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  wire rd_ok = s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= `SWT_OFF_DIR;

  always @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SWT_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `SWT_RESP_OKAY : `SWT_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign irq = |(status_q & mask_q);
endmodule

//--- verif/swt_timer_asserts.sv
// port-level assertions for the waveform timer, bound to its top module
`timescale 1ns/1ps
module swt_timer_chk (
  input wire mclk, // clock
  input wire reset, // sync reset
  input wire timer_tick_enable, // count enable
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_wvalid, // w valid
  input wire s_axi_wready, // w ready
  input wire [1:0] s_axi_bresp, // b resp
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire [31:0] s_axi_rdata, // r data
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire pin_oe_n_a, // pin a enable
  input wire pin_oe_n_b, // pin b enable
  input wire compare_out_a, // compare a
  input wire compare_out_b // compare b
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // no tick and no write in flight: nothing may move the compare outputs
  sequence s_quiet;
    !timer_tick_enable && !s_axi_awvalid && !s_axi_wvalid;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_tick_gate;
    s_quiet ##1 s_quiet ##1 s_quiet |-> $stable(compare_out_a) && $stable(compare_out_b);
  endproperty
  property p_rst_out;
    $fell(reset) |-> pin_oe_n_a && pin_oe_n_b && !compare_out_a && !compare_out_b;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_w_ans;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_ar_ref;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_tick_gate: assert property (p_tick_gate) else $error("compare output moved without tick");
  a_rst_out: assert property (p_rst_out) else $error("outputs not at reset level");
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  a_w_ans: assert property (p_w_ans) else $error("write response late");
  a_r_ans: assert property (p_r_ans) else $error("read data late");
  a_ar_ref: assert property (p_ar_ref) else $error("read address taken while busy");
  a_b_once: assert property (p_b_once) else $error("write response repeated");
endmodule
bind swt_timer swt_timer_chk i_swt_timer_chk (.mclk, .reset, .timer_tick_enable, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_oe_n_a, .pin_oe_n_b, .compare_out_a, .compare_out_b);

//--- verif/tb_top.sv
// self-checking bench for the waveform timer over its register bus
`timescale 1ns/1ps
`include "swt_defines.vh"
module tb_top;
  logic mclk, reset, timer_tick_enable, port_out_a, port_out_b, s_axi_awvalid, s_axi_wvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [1:0] rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, compare_out_a, compare_out_b;
  wire pin_out_a, pin_out_b, pin_oe_n_a, pin_oe_n_b, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int mismatches, num_checks, cyc, h, t;
  swt_timer i_swt_timer (.mclk, .reset, .timer_tick_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_out_a, .port_out_b, .pin_out_a, .pin_oe_n_a, .pin_out_b, .pin_oe_n_b, .compare_out_a, .compare_out_b, .irq);
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  task automatic finish_test;
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, well above the few thousand cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 20000) begin
      mismatches++;
      finish_test;
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (e !== g) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, input int hi, input int g);
    num_checks++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad, dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_bready <= 1;
    while (!(ad && dd)) begin
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !dd;
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) ad = 1;
      if (s_axi_wvalid && s_axi_wready === 1'b1) dd = 1;
    end
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    @(posedge mclk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge mclk);
  endtask
  task automatic cfg(input logic [3:0] m, input logic [1:0] ma, input logic [1:0] mb);
    wr(`SWT_OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
    wr(`SWT_OFF_CTRL_A, {24'h0, ma, mb, 2'b00, m[1:0]});
  endtask
  // settle past any buffered compare load, then count pin a high cycles and edges
  task automatic meas(input int n);
    logic last;
    h = 0;
    t = 0;
    repeat (520) @(posedge mclk);
    last = pin_out_a;
    repeat (n) begin
      @(posedge mclk);
      h += (pin_out_a === 1'b1);
      t += (pin_out_a !== last);
      last = pin_out_a;
    end
  endtask
  initial begin
    reset = 1;
    timer_tick_enable = 0;
    port_out_a = 1;
    port_out_b = 1;
    s_axi_awvalid = 0;
    s_axi_wvalid = 0;
    s_axi_bready = 0;
    s_axi_arvalid = 0;
    s_axi_rready = 0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    repeat (10) @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    chk("oe_a_reset", 1, pin_oe_n_a);
    rd_reg(`SWT_OFF_CTRL_A);
    chk("ctrl_a_reset", `SWT_CTRL_A_RST, rd);
    wr(`SWT_OFF_CTRL_A, 32'hff);
    rd_reg(`SWT_OFF_CTRL_A);
    chk("ctrl_a_reserved", 32'hf3, rd);
    rd_reg(8'h40);
    chk("unmapped_resp", `SWT_RESP_SLVERR, rs);
    cfg(4'd0, 2'b00, 2'b00);
    chk("oe_a_input", 1, pin_oe_n_a);
    wr(`SWT_OFF_DIR, 32'h3);
    chk("oe_a_output", 0, pin_oe_n_a);
    chk("oe_b_output", 0, pin_oe_n_b);
    chk("pin_a_port", 1, pin_out_a);
    rd_reg(`SWT_OFF_COUNTER);
    chk("counter_no_tick", 0, rd);
    wr(`SWT_OFF_CMP_A, 32'h10);
    cfg(4'd4, 2'b01, 2'b00);
    timer_tick_enable <= 1;
    meas(340);
    rng("ctc_toggles", 19, 21, t);
    cfg(4'd4, 2'b11, 2'b11);
    repeat (40) @(posedge mclk);
    chk("ctc_set", 1, pin_out_a);
    chk("ctc_set_b", 1, pin_out_b);
    chk("cmp_b_set", 1, compare_out_b);
    cfg(4'd4, 2'b10, 2'b10);
    repeat (40) @(posedge mclk);
    chk("ctc_clear", 0, pin_out_a);
    chk("ctc_clear_b", 0, pin_out_b);
    wr(`SWT_OFF_CMP_A, 32'h20);
    cfg(4'd15, 2'b01, 2'b01);
    meas(330);
    rng("fast15_toggles", 9, 11, t);
    chk("pin_b_port", port_out_b, pin_out_b);
    wr(`SWT_OFF_CAPTURE, 32'h20);
    cfg(4'd14, 2'b10, 2'b00);
    meas(100);
    rng("fast_match_at_top", 100, 100, h);
    cfg(4'd9, 2'b01, 2'b00);
    meas(320);
    rng("pfc9_toggles", 4, 6, t);
    wr(`SWT_OFF_CMP_A, 32'h40);
    cfg(4'd5, 2'b10, 2'b00);
    meas(256);
    rng("fast_clear_duty", 64, 66, h);
    cfg(4'd5, 2'b11, 2'b00);
    meas(256);
    rng("fast_set_duty", 190, 192, h);
    cfg(4'd5, 2'b01, 2'b00);
    chk("fast_01_off", port_out_a, pin_out_a);
    timer_tick_enable <= 0;
    rd_reg(`SWT_OFF_STATUS);
    chk("ovf_flag", 1, rd[`SWT_ST_OVF]);
    chk("match_a_flag", 1, rd[`SWT_ST_MATCH_A]);
    chk("match_b_flag", 1, rd[`SWT_ST_MATCH_B]);
    chk("irq_masked", 0, irq);
    wr(`SWT_OFF_MASK, 32'h1);
    chk("irq_on", 1, irq);
    wr(`SWT_OFF_STATUS, 32'h7);
    chk("irq_cleared", 0, irq);
    rd_reg(`SWT_OFF_STATUS);
    chk("status_cleared", 0, rd[2:0]);
    timer_tick_enable <= 1;
    cfg(4'd1, 2'b10, 2'b00);
    meas(510);
    rng("phase_duty", 126, 130, h);
    cfg(4'd1, 2'b01, 2'b00);
    chk("phase_01_off", port_out_a, pin_out_a);
    finish_test;
  end
endmodule
